//--- rtl/watchdog_defs.vh
// Shared constants of the one-time-enable watchdog: register indices,
// field positions, reset values, unlock keys and timing counts.
// Assumes inclusion by bare name from every rtl file that needs it.
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// Register indices; the byte address on the bus is four times the index
`define WDT_IDX_W           10
`define WDT_IDX_SERVICE     10'h0A6
`define WDT_IDX_AUX         10'h08E
`define WDT_IDX_STATUS      10'h0B0
`define WDT_IDX_MASK        10'h0B1
`define WDT_IDX_STATE       10'h0B2

// Auxiliary control fields and reset value
`define WDT_AUX_RSTOUT_DIS  3
`define WDT_AUX_IDLE_HALT   4
`define WDT_AUX_RESET       8'h00

// Unlock keys written to the service register
`define WDT_KEY_FIRST       8'h1E
`define WDT_KEY_SECOND      8'hE1

// Counter width and terminal count
`define WDT_CNT_W           14
`define WDT_CNT_MAX         14'h3FFF

// Event bits of the status and mask registers
`define WDT_EV_ARM          0
`define WDT_EV_SERVICE      1
`define WDT_EV_OVERFLOW     2
`define WDT_EV_W            3

// State register bit positions
`define WDT_ST_ARMED        0
`define WDT_ST_PDOWN        1
`define WDT_ST_WAKE_HOLD    2
`define WDT_ST_RST_PULSE    3
`define WDT_ST_RST_PIN      4

// Timing: the clock is the oscillator, a machine cycle is 12 periods
`define WDT_CLK_PERIOD_NS   40
`define WDT_OSC_PERIOD_NS   40
`define WDT_OSC_PER_MC      12
`define WDT_MC_NS           (`WDT_OSC_PER_MC * `WDT_OSC_PERIOD_NS)
`define WDT_MC_CYC          (`WDT_MC_NS / `WDT_CLK_PERIOD_NS)
`define WDT_RSTOUT_NS       (98 * `WDT_OSC_PERIOD_NS)
`define WDT_RSTOUT_CYC      ((`WDT_RSTOUT_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)

`endif

//--- rtl/wdt_unlock_detect.v
// Detects the two-byte unlock sequence on the service register.
// Assumes one write strobe per accepted bus write, same clock.
`include "watchdog_defs.vh"

module wdt_unlock_detect (
   // Clock and resets
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       watchdog_service,
   // Service register write
   input  wire       svcWr,
   input  wire [7:0] svcData,
   // Completed sequence, one-cycle pulse
   output reg        seqDone
);

   reg primed_q;   // First key seen by the last service write
   reg primed_d;

   // Next state of the primed flag
   always @* begin
      primed_d = primed_q;
      if (svcWr) begin
         // Any other value drops the half-done sequence
         primed_d = (svcData == `WDT_KEY_FIRST);
      end
   end

   // Done only when the second key follows the first directly
   always @(posedge ref_clk) begin
      if (rst || watchdog_service) begin
         primed_q <= 1'b0;
         seqDone  <= 1'b0;
      end else begin
         primed_q <= primed_d;
         seqDone  <= svcWr && primed_q && (svcData == `WDT_KEY_SECOND);
      end
   end

endmodule // wdt_unlock_detect

//--- rtl/wdt_reset_pulse.v
// Stretches an overflow into a fixed-length reset pulse.
// Assumes start is a one-cycle pulse; a start during a pulse is ignored.
`include "watchdog_defs.vh"

module wdt_reset_pulse #(
   parameter LEN = `WDT_RSTOUT_CYC
) (
   // Clock and reset
   input  wire ref_clk,
   input  wire rst,
   // Pulse request and pin-drive disable sampled at start
   input  wire start,
   input  wire drvDis,
   // Pulse level and pin drive permission
   output reg  active,
   output reg  drive
);

   reg [7:0] left_q;   // Cycles of the pulse still to go

   // Load on start, count down, drop after the last cycle
   always @(posedge ref_clk) begin
      if (rst) begin
         left_q <= 8'h00;
         active <= 1'b0;
         drive  <= 1'b0;
      end else if (start && !active) begin
         left_q <= LEN[7:0] - 8'h01;
         active <= 1'b1;
         // Disable is caught here since the overflow clears the control bit
         drive  <= !drvDis;
      end else if (active) begin
         if (left_q == 8'h00) begin
            active <= 1'b0;
            drive  <= 1'b0;
         end else begin
            left_q <= left_q - 8'h01;
         end
      end
   end

endmodule // wdt_reset_pulse

//--- rtl/one_time_enable_watchdog.v
// One-time-enable watchdog with reset-out, behind a classic Wishbone slave.
// Assumes ref_clk is the oscillator; power-down entry, idle level and the
// interrupt enables come from core logic on the same clock, the external
// interrupt lines and the reset pin come from pins.
//
// Implementation choice: register access over Wishbone.
`include "watchdog_defs.vh"

module one_time_enable_watchdog #(
   parameter MC_CYC     = `WDT_MC_CYC,
   parameter RSTOUT_CYC = `WDT_RSTOUT_CYC
) (
   // Clock and synchronous reset
   input  wire        ref_clk,
   input  wire        rst,
   // Wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [11:0] adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // Core power state
   input  wire        pdEnter,
   input  wire        idleMode,
   // External interrupt lines and their enables
   input  wire        extIrqLineA_n,
   input  wire        extIrqLineB_n,
   input  wire        irqEnA,
   input  wire        irqEnB,
   // Reset pin, two-way
   input  wire        rstPinIn,
   output wire        rstPinOut,
   output wire        rstPinOe_n,
   // Reset to the rest of the device
   output wire        deviceReset,
   // Power state seen by the core
   output wire        pdActive,
   // Interrupt
   output wire        irq
);

   // Power states, one-hot
   localparam [2:0] ST_RUN  = 3'b001;
   localparam [2:0] ST_PD   = 3'b010;
   localparam [2:0] ST_WAKE = 3'b100;

   // Register index decode, used by both read and write paths
   function hit;
      input [11:0] adr;
      input [9:0]  idx;
      begin
         hit = (adr[11:2] == idx);
      end
   endfunction

   // Pin synchronisers
   reg        irqA1_q;       // Stage one, line A
   reg        irqA_q;        // Stage two, line A
   reg        irqB1_q;       // Stage one, line B
   reg        irqB_q;        // Stage two, line B
   reg        rstPin1_q;     // Stage one, reset pin
   reg        rstPin_q;      // Stage two, reset pin

   // Bus side
   wire       busReq;        // New request this cycle
   wire       wrEn;          // Write accepted, low byte enabled
   wire       svcWr;         // Service register write

   // Registers
   reg  [7:0] aux_q;         // Auxiliary control
   reg  [`WDT_EV_W-1:0] status_q; // Sticky events
   reg  [`WDT_EV_W-1:0] status_d;
   reg  [`WDT_EV_W-1:0] mask_q;   // Interrupt mask

   // Watchdog core
   reg        armed_q;       // Armed, only a reset clears it
   reg  [`WDT_CNT_W-1:0] count_q; // Machine-cycle count
   reg  [7:0] mcDiv_q;       // Oscillator periods within a machine cycle
   wire       mcEn;          // One pulse per machine cycle
   wire       seqDone;       // Unlock sequence completed
   wire       overflow;      // Terminal count reached
   wire       running;       // Oscillator up and watchdog not held
   wire       idleHold;      // Idle with halt selected

   // Power state
   reg  [2:0] pstate_q;
   reg  [2:0] pstate_d;
   reg        wakeByB_q;     // Line B ended the power-down
   reg        wakeByB_d;

   // Reset pulse
   wire       pulseActive;
   wire       pulseDrive;

   // Two flip-flops on every pin before any logic reads it
   always @(posedge ref_clk) begin
      if (rst) begin
         irqA1_q   <= 1'b1;
         irqA_q    <= 1'b1;
         irqB1_q   <= 1'b1;
         irqB_q    <= 1'b1;
         rstPin1_q <= 1'b0;
         rstPin_q  <= 1'b0;
      end else begin
         irqA1_q   <= extIrqLineA_n;
         irqA_q    <= irqA1_q;
         irqB1_q   <= extIrqLineB_n;
         irqB_q    <= irqB1_q;
         rstPin1_q <= rstPinIn;
         rstPin_q  <= rstPin1_q;
      end
   end

   // Bus decode: ack one cycle after the request, dropped the next cycle
   assign busReq = cyc_i && stb_i && !ack_o;
   assign wrEn   = busReq && we_i && sel_i[0];
   assign svcWr  = wrEn && hit(adr_i, `WDT_IDX_SERVICE);

   // Acknowledge and read data; unmapped and write-only read as zero
   always @(posedge ref_clk) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= busReq;
         dat_o <= 32'h0000_0000;
         if (busReq && !we_i) begin
            if (hit(adr_i, `WDT_IDX_AUX)) begin
               dat_o[7:0] <= aux_q;
            end else if (hit(adr_i, `WDT_IDX_STATUS)) begin
               dat_o[`WDT_EV_W-1:0] <= status_q;
            end else if (hit(adr_i, `WDT_IDX_MASK)) begin
               dat_o[`WDT_EV_W-1:0] <= mask_q;
            end else if (hit(adr_i, `WDT_IDX_STATE)) begin
               dat_o[`WDT_ST_ARMED]     <= armed_q;
               dat_o[`WDT_ST_PDOWN]     <= pstate_q[1];
               dat_o[`WDT_ST_WAKE_HOLD] <= pstate_q[2];
               dat_o[`WDT_ST_RST_PULSE] <= pulseActive;
               dat_o[`WDT_ST_RST_PIN]   <= rstPin_q;
            end
            // Service register and counter never read back
         end
      end
   end

   // Auxiliary control; only the two defined bits are kept
   always @(posedge ref_clk) begin
      if (rst || overflow) begin
         aux_q <= `WDT_AUX_RESET;
      end else if (wrEn && hit(adr_i, `WDT_IDX_AUX)) begin
         aux_q <= 8'h00;
         aux_q[`WDT_AUX_IDLE_HALT]  <= dat_i[`WDT_AUX_IDLE_HALT];
         aux_q[`WDT_AUX_RSTOUT_DIS] <= dat_i[`WDT_AUX_RSTOUT_DIS];
      end
   end

   // Sticky events, write one to clear, a new event wins over the clear
   always @* begin
      status_d = status_q;
      if (wrEn && hit(adr_i, `WDT_IDX_STATUS)) begin
         status_d = status_q & ~dat_i[`WDT_EV_W-1:0];
      end
      status_d[`WDT_EV_ARM]      = status_d[`WDT_EV_ARM] | (seqDone & !armed_q);
      status_d[`WDT_EV_SERVICE]  = status_d[`WDT_EV_SERVICE] | (seqDone & armed_q);
      status_d[`WDT_EV_OVERFLOW] = status_d[`WDT_EV_OVERFLOW] | overflow;
   end

   // Status and mask survive the overflow so software can see the cause
   always @(posedge ref_clk) begin
      if (rst) begin
         status_q <= {`WDT_EV_W{1'b0}};
         mask_q   <= {`WDT_EV_W{1'b0}};
      end else begin
         status_q <= status_d;
         if (wrEn && hit(adr_i, `WDT_IDX_MASK)) begin
            mask_q <= dat_i[`WDT_EV_W-1:0];
         end
      end
   end

   assign irq = |(status_q & mask_q);

   // Unlock sequence on the service register
   wdt_unlock_detect u_unlock (
      .ref_clk (ref_clk),
      .rst     (rst),
      .watchdog_service  (overflow),
      .svcWr   (svcWr),
      .svcData (dat_i[7:0]),
      .seqDone (seqDone)
   );

   // Power state: run, oscillator stopped, waiting for the wake line high
   always @* begin
      pstate_d  = pstate_q;
      wakeByB_d = wakeByB_q;
      case (pstate_q)
         ST_RUN: begin
            if (pdEnter) begin
               pstate_d = ST_PD;
            end
         end
         ST_PD: begin
            // Only a low level on an enabled line ends it
            if (irqEnA && !irqA_q) begin
               pstate_d  = ST_WAKE;
               wakeByB_d = 1'b0;
            end else if (irqEnB && !irqB_q) begin
               pstate_d  = ST_WAKE;
               wakeByB_d = 1'b1;
            end
         end
         ST_WAKE: begin
            // Oscillator settles while the line is low; start on release
            if (wakeByB_q ? irqB_q : irqA_q) begin
               pstate_d = ST_RUN;
            end
         end
         default: begin
            pstate_d = ST_RUN;
         end
      endcase
   end

   // Hardware reset also ends power-down
   always @(posedge ref_clk) begin
      if (rst || overflow) begin
         pstate_q  <= ST_RUN;
         wakeByB_q <= 1'b0;
      end else begin
         pstate_q  <= pstate_d;
         wakeByB_q <= wakeByB_d;
      end
   end

   assign pdActive = !pstate_q[0];

   // Counting allowed only with the oscillator up and no hold in force
   assign idleHold = idleMode && aux_q[`WDT_AUX_IDLE_HALT];
   assign running  = pstate_q[0] && !idleHold;

   // Machine-cycle divider; frozen with the count so phase is kept
   always @(posedge ref_clk) begin
      if (rst || overflow) begin
         mcDiv_q <= 8'h00;
      end else if (running) begin
         if (mcDiv_q == MC_CYC[7:0] - 8'h01) begin
            mcDiv_q <= 8'h00;
         end else begin
            mcDiv_q <= mcDiv_q + 8'h01;
         end
      end
   end

   assign mcEn = running && (mcDiv_q == MC_CYC[7:0] - 8'h01);

   // Terminal count raises the watchdog's own reset for one cycle
   assign overflow = armed_q && (count_q == `WDT_CNT_MAX);

   // Arm, service and count; nothing but a reset clears the arm
   always @(posedge ref_clk) begin
      if (rst || overflow) begin
         armed_q <= 1'b0;
         count_q <= {`WDT_CNT_W{1'b0}};
      end else begin
         if (seqDone) begin
            armed_q <= 1'b1;
            count_q <= {`WDT_CNT_W{1'b0}};
         end else if (armed_q && mcEn) begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   // Reset-out pulse after overflow
   wdt_reset_pulse #(
      .LEN (RSTOUT_CYC)
   ) u_pulse (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (overflow),
      .drvDis  (aux_q[`WDT_AUX_RSTOUT_DIS]),
      .active  (pulseActive),
      .drive   (pulseDrive)
   );

   // Pin driven high for the pulse unless reset-out is disabled
   assign rstPinOut   = pulseActive;
   assign rstPinOe_n  = !pulseDrive;
   assign deviceReset = pulseActive;

endmodule // one_time_enable_watchdog

//--- verif/one_time_enable_watchdog_sva.sv
// Checker for the watchdog: bus handshake, reset pulse shape, earliest overflow.
// Assumes it is bound to the watchdog top and sees only its ports.
module one_time_enable_watchdog_sva #(
   parameter MC_CYC     = 12,
   parameter RSTOUT_CYC = 98
) (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // Bus handshake
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   // Reset outputs
   input wire logic        rstPinOut,
   input wire logic        rstPinOe_n,
   input wire logic        deviceReset
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0]  pulseLen_q;  // High cycles of the current pulse
   logic [17:0] sinceRst_q;  // Cycles since any reset, saturating

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Pulse length, cleared whenever the pulse is low
   always_ff @(posedge ref_clk) begin
      if (rst || !deviceReset) pulseLen_q <= 8'h00;
      else pulseLen_q <= pulseLen_q + 8'h01;
   end

   // Saturation keeps the earliest-overflow test valid on long runs
   always_ff @(posedge ref_clk) begin
      if (rst || deviceReset) sinceRst_q <= 18'h0_0000;
      else if (sinceRst_q != 18'h3_FFFF) sinceRst_q <= sinceRst_q + 18'h0_0001;
   end

   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing one cycle after request");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");
   a_pulse_len: assert property ($fell(deviceReset) |-> pulseLen_q == RSTOUT_CYC)
      else $error("reset pulse length wrong");
   a_pulse_max: assert property (deviceReset |-> pulseLen_q < RSTOUT_CYC)
      else $error("reset pulse too long");
   a_pin_in_pulse: assert property (rstPinOut |-> deviceReset)
      else $error("reset pin high outside pulse");
   a_drive_pin: assert property (!rstPinOe_n |-> rstPinOut)
      else $error("reset pin driven without high level");
   a_no_early: assert property ($rose(deviceReset) |-> sinceRst_q >= 16383 * MC_CYC)
      else $error("overflow earlier than full count after reset");

   c_overflow: cover property ($rose(deviceReset));
   c_read: cover property (ack_o && dat_o != 32'h0000_0000);
   c_pin: cover property (!rstPinOe_n);
endmodule // one_time_enable_watchdog_sva

bind one_time_enable_watchdog one_time_enable_watchdog_sva #(
   .MC_CYC    (MC_CYC),
   .RSTOUT_CYC(RSTOUT_CYC)
) checker_i (
   .ref_clk    (ref_clk),
   .rst        (rst),
   .cyc_i      (cyc_i),
   .stb_i      (stb_i),
   .ack_o      (ack_o),
   .dat_o      (dat_o),
   .rstPinOut  (rstPinOut),
   .rstPinOe_n (rstPinOe_n),
   .deviceReset(deviceReset)
);

//--- verif/one_time_enable_watchdog_bench.sv
// Self-checking bench for the one-time-enable watchdog.
// Assumes the design is built with a one-clock machine cycle to keep runs short.
module one_time_enable_watchdog_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int MC    = 1;      // Shortened machine cycle
   localparam int PULSE = 98;     // Reset pulse in clocks
   localparam int TMO   = 16383;  // Terminal count
   localparam logic [11:0] SVC = 12'h298, AUX = 12'h238, STS = 12'h2C0;
   localparam logic [11:0] MSK = 12'h2C4, STA = 12'h2C8;

   // Clock, reset and bus
   logic        ref_clk, rst, cyc_i, stb_i, we_i;
   logic [11:0] adr_i;
   logic [31:0] dat_i, rdData;
   // Power state and wake lines
   logic        pdEnter, idleMode, extIrqLineA_n, irqEnA, extIrqLineB_n, irqEnB;
   // Outputs
   wire  [31:0] dat_o;
   wire         ack_o, rstPinOut, rstPinOe_n, deviceReset, pdActive, irq;
   int          errTotal = 0, testsRun = 0, rstSeen = 0, n;
   // Table rows: write flag, address, write data or expected read
   typedef struct packed {logic w; logic [11:0] a; logic [7:0] d;} row_t;
   row_t rows [10] = '{{1'b0, AUX, 8'h00}, {1'b0, STA, 8'h00}, {1'b0, SVC, 8'h00},
      {1'b0, 12'h000, 8'h00}, {1'b1, MSK, 8'h07}, {1'b0, MSK, 8'h07}, {1'b1, AUX, 8'h90},
      {1'b0, AUX, 8'h10}, {1'b1, AUX, 8'h00}, {1'b0, STS, 8'h00}};

   one_time_enable_watchdog #(.MC_CYC(MC), .RSTOUT_CYC(PULSE)) dut (
      .ref_clk(ref_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .pdEnter(pdEnter), .idleMode(idleMode), .extIrqLineA_n(extIrqLineA_n),
      .extIrqLineB_n(extIrqLineB_n), .irqEnA(irqEnA), .irqEnB(irqEnB), .rstPinIn(1'b0),
      .rstPinOut(rstPinOut), .rstPinOe_n(rstPinOe_n), .deviceReset(deviceReset),
      .pdActive(pdActive), .irq(irq));

   // 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Counts every clock with the device reset high
   always @(posedge ref_clk) if (deviceReset === 1'b1) rstSeen <= rstSeen + 1;

   // Hang guard for the whole run
   initial begin
      repeat (100000) @(posedge ref_clk);
      errTotal++;
      $display("timeout: run limit reached");
      final_report();
   end

   task automatic final_report();
      $display("compares %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         errTotal++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   // Classic single cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r);
      int c;
      @(posedge ref_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {24'h00_0000, d};
      c = 0;
      do begin
         @(posedge ref_clk);
         c++;
      end while (ack_o !== 1'b1 && c < 20);
      if (ack_o !== 1'b1) begin
         errTotal++;
         final_report();
      end
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      wb(1'b0, a, 8'h00, r);
      chk(r, {24'h00_0000, e});
   endtask

   // Unlock pair, arms or services
   task automatic arm();
      wr(SVC, 8'h1E);
      wr(SVC, 8'hE1);
   endtask

   // Interrupt level after the register write has settled
   task automatic irqIs(input logic e);
      tick(2);
      chk(irq, e);
   endtask

   // Bounded wait for the overflow pulse
   task automatic ovf(output int c);
      c = 0;
      while (deviceReset !== 1'b1 && c < 20000) begin
         @(posedge ref_clk);
         c++;
      end
      // A missing overflow ends the run as a failure
      if (deviceReset !== 1'b1) begin
         errTotal++;
         final_report();
      end
   endtask

   initial begin
      rst = 1'b1;
      {cyc_i, stb_i, we_i, pdEnter, idleMode} = 5'h00;
      adr_i = 12'h000;
      dat_i = 32'h0000_0000;
      extIrqLineA_n = 1'b1;
      irqEnA = 1'b1;
      extIrqLineB_n = 1'b1;
      irqEnB = 1'b0;
      tick(10);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wb(rows[i].w, rows[i].a, rows[i].d, rdData);
         if (!rows[i].w) chk(rdData, {24'h00_0000, rows[i].d});
      end
      $display("done: register table");
      // Broken unlock sequences
      wr(SVC, 8'h1E);
      wr(SVC, 8'h55);
      wr(SVC, 8'hE1);
      rd(STA, 8'h00);
      wr(SVC, 8'hE1);
      rd(STA, 8'h00);
      arm();
      rd(STA, 8'h01);
      irqIs(1'b1);
      wr(MSK, 8'h00);
      irqIs(1'b0);
      wr(MSK, 8'h07);
      irqIs(1'b1);
      wr(STS, 8'h01);
      irqIs(1'b0);
      // Other writes cannot disarm
      wr(SVC, 8'h00);
      wr(AUX, 8'h00);
      rd(STA, 8'h01);
      $display("done: arming and interrupt");
      // Counting in idle; leave idle periodically to service
      repeat (2) begin
         idleMode <= 1'b1;
         tick(10000);
         idleMode <= 1'b0;
         arm();
      end
      chk(rstSeen, 0);
      wb(1'b0, STS, 8'h00, rdData);
      chk(rdData[1], 1'b1);
      // Idle with halt set holds the count
      wr(AUX, 8'h10);
      arm();
      idleMode <= 1'b1;
      tick(17000);
      chk(rstSeen, 0);
      idleMode <= 1'b0;
      wr(AUX, 8'h00);
      // Idle with halt clear keeps counting to overflow
      arm();
      idleMode <= 1'b1;
      ovf(n);
      chk(n >= TMO * MC && n <= TMO * MC + 16, 1'b1);
      chk(rstPinOut, 1'b1);
      chk(rstPinOe_n, 1'b0);
      n = 0;
      while (deviceReset === 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk(n, PULSE);
      if (n >= 200) final_report();
      idleMode <= 1'b0;
      rd(STA, 8'h00);
      wb(1'b0, STS, 8'h00, rdData);
      chk(rdData[2], 1'b1);
      $display("done: idle and overflow");
      // Power-down freezes the count until the wake line rises; reset-out disabled
      wr(AUX, 8'h08);
      arm();
      pdEnter <= 1'b1;
      tick(1);
      pdEnter <= 1'b0;
      tick(17000);
      chk(pdActive, 1'b1);
      extIrqLineA_n <= 1'b0;
      tick(200);
      chk(pdActive, 1'b1);
      extIrqLineA_n <= 1'b1;
      tick(8);
      chk(pdActive, 1'b0);
      ovf(n);
      chk(n + 8 >= TMO * MC && n + 8 <= TMO * MC + 24, 1'b1);
      chk(rstPinOut, 1'b1);
      chk(rstPinOe_n, 1'b1);
      tick(PULSE + 4);
      $display("done: power-down");
      // Line B wakes only while enabled, and holds the wake until it rises
      pdEnter <= 1'b1;
      tick(1);
      pdEnter <= 1'b0;
      extIrqLineB_n <= 1'b0;
      tick(4);
      rd(STA, 8'h02);
      irqEnB <= 1'b1;
      tick(4);
      rd(STA, 8'h04);
      extIrqLineB_n <= 1'b1;
      tick(4);
      rd(STA, 8'h00);
      $display("done: wake by second line");
      // Hardware reset in mid-run disarms
      arm();
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      rd(STA, 8'h00);
      $display("done: hardware reset");
      final_report();
   end
endmodule // one_time_enable_watchdog_bench
